// ==== cix_defs.vh ====
/*
 * Offsets, field positions, reset values, opcodes and counts for the
 * instruction subset execution block.
 * Assumes byte addresses on a 32-bit Avalon-MM slave port, word aligned.
 */
`ifndef CIX_DEFS_VH
`define CIX_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CIX_CMD        11'h000
`define CIX_IMM        11'h004
`define CIX_PSW        11'h008
`define CIX_USP        11'h00C
`define CIX_SSP        11'h010
`define CIX_PC         11'h014
`define CIX_SPC        11'h018
`define CIX_IST        11'h01C
`define CIX_IMSK       11'h020
`define CIX_STAT       11'h024
`define CIX_GO         11'h028
`define CIX_DREG_PAGE  6'h02
`define CIX_AREG_PAGE  6'h03

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIX_OP_LSB     0
`define CIX_RX_LSB     8
`define CIX_RY_LSB     12
`define CIX_DIR_BIT    16
`define CIX_LONG_BIT   17
`define CIX_ALT_BIT    18
`define CIX_MEM_BIT    19
`define CIX_SUP_BIT    13
`define CIX_X_BIT      4
`define CIX_N_BIT      3
`define CIX_Z_BIT      2
`define CIX_C_BIT      0
`define CIX_SFC_LSB    0
`define CIX_DFC_LSB    4
`define CIX_EV_DONE    0
`define CIX_EV_TRAP    1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CIX_PSW_RST    16'h2700
`define CIX_RST_CYC    10'd512
`define CIX_FRM_SHORT  32'h0000_0008
`define CIX_FRM_LONG   32'h0000_000C
`define CIX_FMT_LONG   4'h2

// ----------------------------------------
// Opcodes; privileged ones sit below the limit
// ----------------------------------------
`define CIX_OP_MUSP    5'd0
`define CIX_OP_MOVC    5'd1
`define CIX_OP_MOVS    5'd2
`define CIX_OP_ORSR    5'd3
`define CIX_OP_RST     5'd4
`define CIX_OP_RTE     5'd5
`define CIX_OP_PRIV    5'd6
`define CIX_OP_MUL     5'd6
`define CIX_OP_NEG     5'd7
`define CIX_OP_DNEG    5'd8
`define CIX_OP_OR      5'd9
`define CIX_OP_ORI     5'd10
`define CIX_OP_ORCC    5'd11
`define CIX_OP_MOVQ    5'd12
`define CIX_OP_PEA     5'd13
`define CIX_OP_RTD     5'd14
`define CIX_OP_RTR     5'd15
`define CIX_OP_ROT     5'd16
`define CIX_OP_ROTX    5'd17
`define CIX_OP_MOVM    5'd18

`endif

// ==== cix_exec.v ====
/*
 * Execution unit for a subset of a 32-bit core's instruction set, with its
 * own data, address and control registers and a two-bank stack memory.
 * Assumes one 25 MHz clock, a synchronous active-high reset and an
 * Avalon-MM master that holds each request until waitrequest is low.
 */
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cix_defs.vh"
// Notes on behaviour
// - User stack pointer move_alternate_space_op to or from an address register in supervisor only.
// - Control register move_alternate_space_op to or from a data register in supervisor only.
// - Alternate space move_alternate_space_op use destination code to write, source code to read.
// - OR-immediate to status word merges the full word, supervisor only.
// - Reset instruction drives the external reset output, supervisor only.
// - Exception return pops status, program counter, then frees frame by format.
// - Multiply: word 16x16 to 32, long to 32 or 64 over two registers.
// - Negate is zero minus operand; extended forms also subtract extend; decimal form.
// - OR combines memory operand with data register into either one.
// - OR-immediate into destination; flags-byte form allowed in any state.
// - Quick move loads a sign-extended instruction constant into a data register.
// - Push address drops stack pointer by 4, stores the address itself.
// - Return-and-deallocate pops program counter, adds 4 plus displacement.
// - Return-restore-codes pops flags byte, then program counter, stack up 6.
// - Plain rotate by register count, immediate count, or one for memory.
// - Rotate through extend treats the extend flag as an extra ring bit.
// - Register list move stores or loads the selected registers by direction.
// - Direction bit selects left or right for rotates.

module cix_exec (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [10:0] avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	output wire        irq_o,
	output wire        ext_reset_o
);

	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_EXEC = 4'b0010;
	localparam [3:0] S_LIST = 4'b0100;
	localparam [3:0] S_RSTO = 4'b1000;

	reg  [31:0] dreg [0:7];
	reg  [31:0] areg [0:6];
	reg  [15:0] mem  [0:255];
	reg  [31:0] usp_q;
	reg  [31:0] ssp_q;
	reg  [31:0] pc_q;
	reg  [31:0] imm_q;
	reg  [15:0] psw_q;
	reg  [19:0] cmd_q;
	reg  [2:0]  sfc_q;
	reg  [2:0]  dfc_q;
	reg  [1:0]  ist_q;
	reg  [1:0]  imsk_q;
	reg  [3:0]  st_q;
	reg  [9:0]  cnt_q;
	reg  [3:0]  lidx_q;
	reg  [7:0]  laddr_q;
	reg         ack_q;
	reg  [31:0] rdata_q;
	reg  [31:0] rmux;
	integer     i;

	// ----------------------------------------
	// Decode and operands
	// ----------------------------------------
	wire [4:0]  op   = cmd_q[`CIX_OP_LSB +: 5];
	wire [2:0]  rx   = cmd_q[`CIX_RX_LSB +: 3];
	wire [2:0]  ry   = cmd_q[`CIX_RY_LSB +: 3];
	wire        dir  = cmd_q[`CIX_DIR_BIT];
	wire        lng  = cmd_q[`CIX_LONG_BIT];
	wire        alt  = cmd_q[`CIX_ALT_BIT];
	wire        memf = cmd_q[`CIX_MEM_BIT];
	wire        sup  = psw_q[`CIX_SUP_BIT];
	wire        xf   = psw_q[`CIX_X_BIT];
	wire [31:0] sp   = sup ? ssp_q : usp_q;
	wire        priv = (op < `CIX_OP_PRIV);
	wire [31:0] bem  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	wire        bw   = avs_write_i & ack_q;

	function [15:0] rd16;
		input       b;
		input [7:0] a;
		rd16 = mem[{b, a[7:1]}];
	endfunction

	function [31:0] rd32;
		input       b;
		input [7:0] a;
		rd32 = {mem[{b, a[7:1]}], mem[{b, a[7:1] + 7'd1}]};
	endfunction

	function [31:0] aval;
		input [2:0] n;
		aval = (n == 3'd7) ? sp : areg[n];
	endfunction

	function [31:0] mg;
		input [31:0] o;
		mg = (o & ~bem) | (avs_writedata_i & bem);
	endfunction

	// Ring of 32 bits, or 33 with extend; one step per count, for every count from 0 up to 63
	function [32:0] rotr;
		input [31:0] v;
		input        x;
		input [5:0]  n;
		input        l;
		input        t;
		integer      k;
		reg   [31:0] r;
		reg          c;
		begin
			r = v;
			c = x;
			for (k = 0; k < 63; k = k + 1) begin
				if (k < n) begin
					if (t) begin
						if (l)
							{c, r} = {r, c};
						else
							{r, c} = {c, r};
					end else if (l)
						r = {r[30:0], r[31]};
					else
						r = {r[0], r[31:1]};
				end
			end
			rotr = {c, r};
		end
	endfunction

	function [8:0] bneg;
		input [7:0] d;
		input       x;
		reg   [4:0] lo;
		reg   [4:0] hi;
		begin
			lo = 5'd0 - {1'b0, d[3:0]} - {4'd0, x};
			if (lo[4])
				lo[3:0] = lo[3:0] - 4'd6;
			hi = 5'd0 - {1'b0, d[7:4]} - {4'd0, lo[4]};
			if (hi[4])
				hi[3:0] = hi[3:0] - 4'd6;
			bneg = {hi[4], hi[3:0], lo[3:0]};
		end
	endfunction

	// ----------------------------------------
	// Datapath results
	// ----------------------------------------
	wire [31:0] src  = dreg[ry];
	wire [31:0] dst  = dreg[rx];
	wire [31:0] ma   = lng ? src : (alt ? {{16{src[15]}}, src[15:0]} : {16'h0000, src[15:0]});
	wire [31:0] mb   = lng ? dst : (alt ? {{16{dst[15]}}, dst[15:0]} : {16'h0000, dst[15:0]});
	wire [63:0] prod = {{32{alt & ma[31]}}, ma} * {{32{alt & mb[31]}}, mb};
	wire [32:0] ngr  = 33'd0 - {1'b0, dst} - {32'd0, alt & xf};
	wire [8:0]  bn   = bneg(dst[7:0], xf);
	wire [31:0] mrd  = rd32(sup, imm_q[7:0]);
	wire [15:0] mwd  = rd16(sup, imm_q[7:0]);
	wire [15:0] sp_w = rd16(sup, sp[7:0]);
	wire [15:0] fmtw = rd16(1'b1, ssp_q[7:0] + 8'd6);
	wire [31:0] ra   = aval(ry);
	wire [31:0] spm4 = sp - 32'h0000_0004;
	wire        thru = (op == `CIX_OP_ROTX);
	wire [5:0]  rcnt = alt ? ((imm_q[2:0] == 3'd0) ? 6'd8 : {3'd0, imm_q[2:0]}) : dst[5:0];
	wire [32:0] rr   = rotr(src, xf, rcnt, dir, thru);
	wire [16:0] rw   = thru ? (dir ? {mwd, xf} : {mwd[0], xf, mwd[15:1]})
			: (dir ? {xf, mwd[14:0], mwd[15]} : {xf, mwd[0], mwd[15:1]});
	wire [31:0] ctl  = (rx == 3'd0) ? {29'd0, sfc_q} : (rx == 3'd1) ? {29'd0, dfc_q} : usp_q;
	// Read mux already holds the addressed word, so one merge serves the memory, CMD, PSW and IMSK writers
	wire [31:0] wmg  = mg(rmux);
	wire [31:0] wset = avs_writedata_i & bem;

	wire        ex     = (st_q == S_EXEC);
	wire        ev_trap = ex & priv & ~sup;
	wire        go_sub = (op == `CIX_OP_MOVM) | ((op == `CIX_OP_RST) & sup);
	wire        ev_done = (ex & ~go_sub) | ((st_q == S_LIST) & (lidx_q == 4'hF))
			| ((st_q == S_RSTO) & (cnt_q == 10'd0));

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign avs_readdata_o    = rdata_q;
	assign irq_o             = |(ist_q & imsk_q);
	assign ext_reset_o       = (st_q == S_RSTO);

	// ----------------------------------------
	// Register writers
	// ----------------------------------------
	task wr_a;
		input [2:0]  n;
		input [31:0] v;
		begin
			if (n != 3'd7)
				areg[n] <= v;
			else if (sup)
				ssp_q <= v;
			else
				usp_q <= v;
		end
	endtask

	task wr_m32;
		input        b;
		input [7:0]  a;
		input [31:0] v;
		begin
			mem[{b, a[7:1]}] <= v[31:16];
			mem[{b, a[7:1] + 7'd1}] <= v[15:0];
		end
	endtask

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rmux = 32'h0000_0000;
		if (avs_address_i[10])
			rmux = {16'h0000, mem[avs_address_i[9:2]]};
		else if (avs_address_i[10:5] == `CIX_DREG_PAGE)
			rmux = dreg[avs_address_i[4:2]];
		else if (avs_address_i[10:5] == `CIX_AREG_PAGE)
			rmux = aval(avs_address_i[4:2]);
		else begin
			case (avs_address_i)
			`CIX_CMD:  rmux = {12'h000, cmd_q};
			`CIX_IMM:  rmux = imm_q;
			`CIX_PSW:  rmux = {16'h0000, psw_q};
			`CIX_USP:  rmux = usp_q;
			`CIX_SSP:  rmux = ssp_q;
			`CIX_PC:   rmux = pc_q;
			`CIX_SPC:  rmux = {25'd0, dfc_q, 1'b0, sfc_q};
			`CIX_IST:  rmux = {30'd0, ist_q};
			`CIX_IMSK: rmux = {30'd0, imsk_q};
			`CIX_STAT: rmux = {29'd0, sup, ext_reset_o, ~(st_q == S_IDLE)};
			default:   rmux = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Bus, events and execution
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < 8; i = i + 1) begin
				dreg[i] <= 32'h0000_0000;
			end
			for (i = 0; i < 7; i = i + 1) begin
				areg[i] <= 32'h0000_0000;
			end
			usp_q   <= 32'h0000_0000;
			ssp_q   <= 32'h0000_0000;
			pc_q    <= 32'h0000_0000;
			imm_q   <= 32'h0000_0000;
			psw_q   <= `CIX_PSW_RST;
			cmd_q   <= 20'h0_0000;
			sfc_q   <= 3'd0;
			dfc_q   <= 3'd0;
			ist_q   <= 2'b00;
			imsk_q  <= 2'b00;
			st_q    <= S_IDLE;
			cnt_q   <= 10'd0;
			lidx_q  <= 4'h0;
			laddr_q <= 8'h00;
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
			if (avs_read_i & ~ack_q)
				rdata_q <= rmux;
			// A new event wins over a same-cycle clear
			ist_q <= (ist_q & ~((bw && avs_address_i == `CIX_IST) ? wset[1:0] : 2'b00))
					| {ev_trap, ev_done};
			if (bw && avs_address_i == `CIX_IMSK)
				imsk_q <= wmg[1:0];
			case (st_q)
			S_IDLE: if (bw) begin
				// Architectural state is only writable while idle
				if (avs_address_i[10])
					mem[avs_address_i[9:2]] <= wmg[15:0];
				else if (avs_address_i[10:5] == `CIX_DREG_PAGE)
					dreg[avs_address_i[4:2]] <= mg(dreg[avs_address_i[4:2]]);
				else if (avs_address_i[10:5] == `CIX_AREG_PAGE)
					wr_a(avs_address_i[4:2], mg(aval(avs_address_i[4:2])));
				else begin
					case (avs_address_i)
					`CIX_CMD: cmd_q <= wmg[19:0];
					`CIX_IMM: imm_q <= mg(imm_q);
					`CIX_PSW: psw_q <= wmg[15:0];
					`CIX_USP: usp_q <= mg(usp_q);
					`CIX_SSP: ssp_q <= mg(ssp_q);
					`CIX_PC:  pc_q <= mg(pc_q);
					`CIX_SPC: begin
						sfc_q <= avs_writedata_i[`CIX_SFC_LSB +: 3];
						dfc_q <= avs_writedata_i[`CIX_DFC_LSB +: 3];
					end
					`CIX_GO:  st_q <= S_EXEC;
					default: ;
					endcase
				end
			end
			S_EXEC: begin
				st_q <= S_IDLE;
				if (priv & ~sup) begin
					// Suppressed: the trap event and the done event are both raised
				end else begin
					case (op)
					`CIX_OP_MUSP: if (dir)
						usp_q <= aval(rx);
					else
						wr_a(rx, usp_q);
					`CIX_OP_MOVC: if (dir) begin
						if (rx == 3'd0)
							sfc_q <= src[2:0];
						else if (rx == 3'd1)
							dfc_q <= src[2:0];
						else
							usp_q <= src;
					end else
						dreg[ry] <= ctl;
					`CIX_OP_MOVS: if (dir)
						wr_m32(dfc_q[2], imm_q[7:0], dst);
					else
						dreg[rx] <= rd32(sfc_q[2], imm_q[7:0]);
					`CIX_OP_ORSR: psw_q <= psw_q | imm_q[15:0];
					`CIX_OP_RST: begin
						st_q  <= S_RSTO;
						cnt_q <= `CIX_RST_CYC - 10'd1;
					end
					`CIX_OP_RTE: begin
						psw_q <= rd16(1'b1, ssp_q[7:0]);
						pc_q  <= rd32(1'b1, ssp_q[7:0] + 8'd2);
						ssp_q <= ssp_q + ((fmtw[15:12] == `CIX_FMT_LONG) ?
								`CIX_FRM_LONG : `CIX_FRM_SHORT);
					end
					`CIX_OP_MUL: begin
						dreg[rx] <= prod[31:0];
						if (lng & dir)
							dreg[imm_q[2:0]] <= prod[63:32];
					end
					`CIX_OP_NEG: begin
						dreg[rx] <= ngr[31:0];
						psw_q[`CIX_X_BIT] <= ngr[32];
						psw_q[`CIX_C_BIT] <= ngr[32];
						psw_q[`CIX_N_BIT] <= ngr[31];
						psw_q[`CIX_Z_BIT] <= (ngr[31:0] == 32'h0000_0000);
					end
					`CIX_OP_DNEG: begin
						dreg[rx][7:0] <= bn[7:0];
						psw_q[`CIX_X_BIT] <= bn[8];
						psw_q[`CIX_C_BIT] <= bn[8];
					end
					`CIX_OP_OR: if (dir)
						wr_m32(sup, imm_q[7:0], mrd | dst);
					else
						dreg[rx] <= dst | mrd;
					`CIX_OP_ORI: dreg[rx] <= dst | imm_q;
					`CIX_OP_ORCC: psw_q[4:0] <= psw_q[4:0] | imm_q[4:0];
					`CIX_OP_MOVQ: dreg[rx] <= {{24{imm_q[7]}}, imm_q[7:0]};
					`CIX_OP_PEA: begin
						wr_a(3'd7, spm4);
						wr_m32(sup, spm4[7:0], imm_q);
					end
					`CIX_OP_RTD: begin
						pc_q <= rd32(sup, sp[7:0]);
						wr_a(3'd7, sp + 32'h0000_0004 + {{16{imm_q[15]}}, imm_q[15:0]});
					end
					`CIX_OP_RTR: begin
						psw_q[4:0] <= sp_w[4:0];
						pc_q <= rd32(sup, sp[7:0] + 8'd2);
						wr_a(3'd7, sp + 32'h0000_0006);
					end
					`CIX_OP_ROT, `CIX_OP_ROTX: begin
						if (memf)
							mem[{sup, imm_q[7:1]}] <= rw[15:0];
						else
							dreg[ry] <= rr[31:0];
						if (thru)
							psw_q[`CIX_X_BIT] <= memf ? rw[16] : rr[32];
					end
					`CIX_OP_MOVM: begin
						st_q    <= S_LIST;
						lidx_q  <= 4'h0;
						laddr_q <= ra[7:0];
					end
					default: ;
					endcase
				end
			end
			S_LIST: begin
				// One register per cycle, lowest index first
				if (imm_q[lidx_q]) begin
					if (dir) begin
						if (lidx_q[3])
							wr_a(lidx_q[2:0], rd32(sup, laddr_q));
						else
							dreg[lidx_q[2:0]] <= rd32(sup, laddr_q);
					end else
						wr_m32(sup, laddr_q, lidx_q[3] ? aval(lidx_q[2:0])
								: dreg[lidx_q[2:0]]);
					laddr_q <= laddr_q + 8'd4;
				end
				lidx_q <= lidx_q + 4'h1;
				if (lidx_q == 4'hF)
					st_q <= S_IDLE;
			end
			S_RSTO: begin
				cnt_q <= cnt_q - 10'd1;
				if (cnt_q == 10'd0)
					st_q <= S_IDLE;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

endmodule // cix_exec
`default_nettype wire

// ==== cix_exec_assertions.sv ====
/*
 * Port-level checker for the instruction subset execution block.
 * Assumes one clock, synchronous active-high reset, bound to cix_exec.
 */
`timescale 1ns/1ps
`default_nettype none
module cix_exec_assertions (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        irq_o,
	input wire logic        ext_reset_o
);
	// ----------------------------------------
	// Reset output width counter
	// ----------------------------------------
	logic [9:0] xr_q;
	always @(posedge clk_i) begin
		if (rst_i || !ext_reset_o)
			xr_q <= 10'h000;
		else
			xr_q <= xr_q + 10'h001;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	wait_first_a: assert property ((avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i)
		|-> avs_waitrequest_o) else $error("no wait cycle on new request");
	wait_once_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !(avs_read_i || avs_write_i) || !avs_waitrequest_o) else $error("second wait cycle");
	idle_nowait_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("waitrequest while idle");
	rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved without read");
	xr_width_a: assert property ($fell(ext_reset_o) |-> xr_q == 10'h200)
		else $error("reset output width wrong");
	xr_cause_a: assert property ($rose(ext_reset_o) |-> $past(avs_write_i && !avs_waitrequest_o, 2))
		else $error("reset output without command");
	xr_hold_a: assert property ($rose(ext_reset_o) |=> ext_reset_o [*8])
		else $error("reset output too short");
	irq_fall_a: assert property ($fell(irq_o) |-> $past(avs_write_i && !avs_waitrequest_o))
		else $error("interrupt dropped without write");
endmodule // cix_exec_assertions

bind cix_exec cix_exec_assertions chk_i (
	.clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.irq_o(irq_o), .ext_reset_o(ext_reset_o));
`default_nettype wire

// ==== tb_cpu_instruction_subset_exec.sv ====
/*
 * Self-checking bench for cix_exec: drives commands over the register bus.
 * Assumes cix_defs.vh on the include path and the checker bound beside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cix_defs.vh"
module tb_cpu_instruction_subset_exec;
	logic        clk = 0, rst = 1, rd = 0, wr = 0;
	logic [10:0] adr = 0;
	logic [31:0] wd = 0, r1, r2, r3;
	logic signed [63:0] p;
	wire  [31:0] rdat;
	wire         wt, irq, xr;
	logic [31:0] eq[$];
	logic [10:0] aq[$];
	int          err_count = 0, num_checks = 0, i;

	cix_exec DUT (.clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq), .ext_reset_o(xr));

	initial forever #20 clk = ~clk;

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task ack;
		@(posedge clk);
		while (wt !== 1'b0) @(posedge clk);
	endtask
	task w(input [10:0] a, input [31:0] d);
		adr <= a;
		wd <= d;
		wr <= 1;
		ack;
		wr <= 0;
		@(posedge clk);
	endtask
	task r(input [10:0] a, input [31:0] e);
		eq.push_back(e);
		aq.push_back(a);
		adr <= a;
		rd <= 1;
		ack;
		rd <= 0;
		@(posedge clk);
	endtask
	function [10:0] dr(input [2:0] n);
		dr = {`CIX_DREG_PAGE, n, 2'h0};
	endfunction
	// Ends one idle edge after GO, the execute edge
	task ex(input [4:0] op, input [2:0] x, y, input [3:0] f, input [31:0] im);
		w(`CIX_IMM, im);
		w(`CIX_CMD, {12'h000, f, 1'b0, y, 1'b0, x, 3'h0, op});
		w(`CIX_GO, 1'h1);
	endtask
	task done(input [31:0] e);
		r(`CIX_IST, e);
		w(`CIX_IST, 2'h3);
	endtask

	// Read data compared at the accepting edge
	always @(posedge clk)
		if (rd && wt === 1'b0)
			chk($sformatf("read %h", aq.pop_front()), rdat, eq.pop_front());

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report;
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(57));
		repeat (10) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		r(`CIX_PSW, 16'h2700);
		r(11'h030, 1'h0);
		for (i = 0; i < 2; i++) begin
			r1 = i ? $urandom : 32'h0000_0080;
			ex(`CIX_OP_MOVQ, 3'h1, 3'h0, 4'h0, r1);
			done(1'h1);
			r(dr(1), {{24{r1[7]}}, r1[7:0]});
		end
		w(`CIX_IMSK, 1'h1);
		ex(`CIX_OP_MOVQ, 3'h1, 3'h0, 4'h0, r1);
		// Status bit lands at the execute edge, so look one edge later
		@(posedge clk);
		chk("irq", {31'h0, irq}, 1'h1);
		w(`CIX_IMSK, 1'h0);
		chk("irq masked", {31'h0, irq}, 1'h0);
		done(1'h1);
		r1 = $urandom;
		r2 = $urandom;
		r3 = $urandom;
		w(dr(2), r1);
		ex(`CIX_OP_ORI, 3'h2, 3'h0, 4'h2, r2);
		done(1'h1);
		r(dr(2), r1 | r2);
		w(dr(3), r1);
		ex(`CIX_OP_NEG, 3'h3, 3'h0, 4'h2, 1'h0);
		done(1'h1);
		r(dr(3), -r1);
		w(`CIX_PSW, 16'h2710);
		w(dr(3), r1);
		ex(`CIX_OP_NEG, 3'h3, 3'h0, 4'h6, 1'h0);
		done(1'h1);
		r(dr(3), ~r1);
		w(`CIX_PSW, 16'h2710);
		w(dr(3), 8'h25);
		ex(`CIX_OP_DNEG, 3'h3, 3'h0, 4'h0, 1'h0);
		done(1'h1);
		r(dr(3), 8'h74);
		w(dr(4), r1);
		w(dr(5), r2);
		ex(`CIX_OP_MUL, 3'h4, 3'h5, 4'h0, 1'h0);
		done(1'h1);
		r(dr(4), r1[15:0] * r2[15:0]);
		w(dr(4), r1);
		ex(`CIX_OP_MUL, 3'h4, 3'h5, 4'h7, 3'h6);
		done(1'h1);
		p = $signed(r1) * $signed(r2);
		r(dr(4), p[31:0]);
		r(dr(6), p[63:32]);
		w(dr(1), r1);
		ex(`CIX_OP_ROT, 3'h0, 3'h1, 4'h7, 1'h0);
		done(1'h1);
		r(dr(1), {r1[23:0], r1[31:24]});
		w(dr(0), 3'h5);
		ex(`CIX_OP_ROT, 3'h0, 3'h1, 4'h2, 1'h0);
		done(1'h1);
		r(dr(1), {r1[28:0], r1[31:29]});
		w(`CIX_PSW, 16'h2710);
		w(dr(1), r1);
		ex(`CIX_OP_ROTX, 3'h0, 3'h1, 4'h7, 1'h1);
		done(1'h1);
		r(dr(1), {r1[30:0], 1'b1});
		w(`CIX_SSP, 8'h40);
		ex(`CIX_OP_PEA, 3'h0, 3'h0, 4'h0, r1);
		done(1'h1);
		r(`CIX_SSP, 8'h3C);
		ex(`CIX_OP_RTD, 3'h0, 3'h0, 4'h0, 4'h8);
		done(1'h1);
		r(`CIX_PC, r1);
		r(`CIX_SSP, 8'h48);
		w(`CIX_SSP, 8'h40);
		ex(`CIX_OP_PEA, 3'h0, 3'h0, 4'h0, r1);
		ex(`CIX_OP_PEA, 3'h0, 3'h0, 4'h0, {16'h0015, r2[15:0]});
		ex(`CIX_OP_RTR, 3'h0, 3'h0, 4'h0, 1'h0);
		done(1'h1);
		r(`CIX_PSW, 16'h2715);
		r(`CIX_PC, {r2[15:0], r1[31:16]});
		r(`CIX_SSP, 8'h3E);
		for (i = 0; i < 3; i += 2) begin
			w(`CIX_SSP, 8'h40);
			ex(`CIX_OP_PEA, 3'h0, 3'h0, 4'h0, {r2[15:0], i[3:0], 12'h000});
			ex(`CIX_OP_PEA, 3'h0, 3'h0, 4'h0, {16'h2700, r1[31:16]});
			ex(`CIX_OP_RTE, 3'h0, 3'h0, 4'h0, 1'h0);
			done(1'h1);
			r(`CIX_PC, {r1[31:16], r2[15:0]});
			r(`CIX_SSP, i ? 8'h44 : 8'h40);
		end
		w(dr(2) + 11'h020, r1);
		ex(`CIX_OP_MUSP, 3'h2, 3'h0, 4'h1, 1'h0);
		done(1'h1);
		r(`CIX_USP, r1);
		w(dr(5), 3'h6);
		ex(`CIX_OP_MOVC, 3'h1, 3'h5, 4'h1, 1'h0);
		ex(`CIX_OP_MOVC, 3'h0, 3'h5, 4'h1, 1'h0);
		done(1'h1);
		r(`CIX_SPC, 8'h66);
		w(dr(1), r2);
		ex(`CIX_OP_MOVS, 3'h1, 3'h0, 4'h3, 8'h20);
		ex(`CIX_OP_MOVS, 3'h2, 3'h0, 4'h2, 8'h20);
		done(1'h1);
		r(dr(2), r2);
		w(dr(3) + 11'h020, 8'h80);
		w(dr(0), r1);
		ex(`CIX_OP_MOVM, 3'h0, 3'h3, 4'h0, 2'h3);
		repeat (20) @(posedge clk);
		w(dr(0), 1'h0);
		w(dr(1), 1'h0);
		ex(`CIX_OP_MOVM, 3'h0, 3'h3, 4'h1, 2'h3);
		repeat (20) @(posedge clk);
		done(1'h1);
		r(dr(0), r1);
		r(dr(1), r2);
		w(dr(4), r3);
		ex(`CIX_OP_OR, 3'h4, 3'h0, 4'h2, 8'h80);
		done(1'h1);
		r(dr(4), r1 | r3);
		ex(`CIX_OP_RST, 3'h0, 3'h0, 4'h0, 1'h0);
		@(posedge clk);
		chk("ext reset", {31'h0, xr}, 1'h1);
		repeat (520) @(posedge clk);
		done(1'h1);
		w(`CIX_PSW, 1'h0);
		for (i = 0; i < 6; i++) begin
			ex(i[4:0], 3'h1, 3'h1, 4'h1, 16'hFFFF);
			// A started reset pulse would show one edge after execute
			@(posedge clk);
			chk("ext reset", {31'h0, xr}, 1'h0);
			done(2'h3);
		end
		r(`CIX_PSW, 1'h0);
		r(`CIX_USP, r1);
		r(`CIX_SPC, 8'h66);
		ex(`CIX_OP_ORCC, 3'h0, 3'h0, 4'h0, 8'h1F);
		done(1'h1);
		r(`CIX_PSW, 8'h1F);
		chk("queue", eq.size(), 1'h0);
		final_report;
	end
endmodule // tb_cpu_instruction_subset_exec
`default_nettype wire
